// *** gepio_pkg.sv ***
`default_nettype none
package gepio_pkg;
  // ==========================================================
  // register offsets (configuration space, function 0 only)
  localparam logic [2:0] GEPIO_FUNC0 = 3'h0;
  localparam logic [7:0] GEPIO_OFS_STATUS = 8'ha8;
  localparam logic [7:0] GEPIO_OFS_ENABLE = 8'haa;
  localparam logic [7:0] GEPIO_OFS_INPUT = 8'hac;
  localparam logic [7:0] GEPIO_OFS_OUTPUT = 8'hae;
  // ==========================================================
  // field positions in status and event_enable
  localparam int GEPIO_BIT_VID0 = 15;
  localparam int GEPIO_BIT_VID1 = 14;
  localparam int GEPIO_BIT_PWR = 11;
  localparam int GEPIO_BIT_VPP12 = 8;
  localparam int GEPIO_NUM_PINS = 5;
  // implemented bits: 15, 14, 11, 8 and 4..0
  localparam logic [15:0] GEPIO_EVENT_MASK = 16'hc91f;
  localparam logic [15:0] GEPIO_PIN_MASK = 16'h001f;
  // ==========================================================
  // reset values
  localparam logic [15:0] GEPIO_ENABLE_RST = 16'h0000;
  localparam logic [15:0] GEPIO_STATUS_RST = 16'h0000;
  localparam logic [15:0] GEPIO_OUTPUT_RST = 16'h0000;
  // synchroniser stages to fill before change detection is trusted
  localparam int GEPIO_PRIME_STAGES = 3;
endpackage : gepio_pkg
`default_nettype wire

// *** gepio_sync_if.sv ***
`default_nettype none
interface gepio_sync_if;
  logic [4:0] raw;
  logic [4:0] level;
  logic [4:0] change;
  modport sync (input raw, output level, output change);
  modport user (output raw, input level, input change);
endinterface : gepio_sync_if
`default_nettype wire

// *** gepio_in_sync.sv ***
`default_nettype none
module gepio_in_sync (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  gepio_sync_if.sync pins
);
  import gepio_pkg::*;

  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic [4:0] prev_q;
  logic [GEPIO_PRIME_STAGES-1:0] prime_q;

  // ==========================================================
  // two-flop synchroniser; meta_q feeds sync_q only
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      meta_q <= 5'h0;
      sync_q <= 5'h0;
      prev_q <= 5'h0;
    end else begin
      meta_q <= pins.raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // no change is reported until the pipeline holds real pin levels,
  // otherwise every high pin would look like an edge after reset
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      prime_q <= '0;
    end else begin
      prime_q <= {prime_q[GEPIO_PRIME_STAGES-2:0], 1'b1};
    end
  end

  assign pins.level = sync_q;
  assign pins.change = (sync_q ^ prev_q) & {5{prime_q[GEPIO_PRIME_STAGES-1]}};
endmodule : gepio_in_sync
`default_nettype wire

// *** gepio_top.sv ***
`default_nettype none
// Functional notes
// - event output holds until status bit cleared
// - event output only if routed to pin
// - bit 15 enables socket 0 video change
// - bit 14 enables socket 1 video change
// - bit 11 enables socket power change event
// - bit 8 enables 12 V request change
// - bits 4..0 enable input pin changes
// - reserved enable bits read zero, ignore writes
// - input register reflects five pin levels
// - upper input and output bits read zero
// - output bits drive pins configured as outputs
// - output reads last written, resets to zero
// - writing one clears status, releases event
// - status sets regardless of enable bits
module gepio_top (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // configuration access, 16-bit word at even byte offset
  input wire logic [2:0] cfg_func_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [1:0] cfg_be_i,
  input wire logic cfg_wr_i,
  input wire logic [15:0] cfg_wdata_i,
  input wire logic cfg_rd_i,
  output logic [15:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // state of neighbouring socket registers, same clock
  input wire logic [1:0] video_port_on_bit_i,
  input wire logic [1:0] power_change_i,
  input wire logic [1:0] prog_volt_12v_req_i,
  // pins 5,4,2,1,0 in bits 4..0; mux configuration from terminal mux
  input wire logic [4:0] multipurpose_pin_i,
  output logic [4:0] multipurpose_pin_o,
  output logic [4:0] multipurpose_pin_oe_o,
  input wire logic [4:0] pin_is_input_i,
  input wire logic [4:0] pin_is_output_i,
  input wire logic event_pin_routed_i,
  output logic general_event_out_n_o
);
  import gepio_pkg::*;

  function automatic logic [15:0] byte_mask(input logic [1:0] be);
    byte_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction : byte_mask

  function automatic logic hit(input logic [2:0] func,
                               input logic [7:0] addr,
                               input logic [7:0] ofs);
    hit = (func == GEPIO_FUNC0) && (addr == ofs);
  endfunction : hit

  logic [15:0] enable_q;
  logic [15:0] status_q;
  logic [15:0] output_q;
  logic [15:0] status_set;
  logic [15:0] wmask;
  logic [1:0] video_prev_q;
  logic [1:0] vpp12_prev_q;
  logic event_n_q;
  logic wr_enable;
  logic wr_status;
  logic wr_output;

  gepio_sync_if pin_sync ();

  assign pin_sync.raw = multipurpose_pin_i;

  gepio_in_sync u_in_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i (sys_rst_i),
    .pins (pin_sync.sync)
  );

  // ==========================================================
  // write decode
  assign wmask = byte_mask(cfg_be_i);
  assign wr_enable = cfg_wr_i
                     && hit(cfg_func_i, cfg_addr_i, GEPIO_OFS_ENABLE);
  assign wr_status = cfg_wr_i
                     && hit(cfg_func_i, cfg_addr_i, GEPIO_OFS_STATUS);
  assign wr_output = cfg_wr_i
                     && hit(cfg_func_i, cfg_addr_i, GEPIO_OFS_OUTPUT);

  // ==========================================================
  // event enable
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      enable_q <= GEPIO_ENABLE_RST;
    end else if (wr_enable) begin
      enable_q <= (enable_q & ~wmask)
                | (cfg_wdata_i & wmask & GEPIO_EVENT_MASK);
    end
  end

  // ==========================================================
  // event sources
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      video_prev_q <= 2'h0;
      vpp12_prev_q <= 2'h0;
    end else begin
      video_prev_q <= video_port_on_bit_i;
      vpp12_prev_q <= prog_volt_12v_req_i;
    end
  end

  always_comb begin
    status_set = 16'h0000;
    status_set[GEPIO_BIT_VID0] =
      video_port_on_bit_i[0] ^ video_prev_q[0];
    status_set[GEPIO_BIT_VID1] =
      video_port_on_bit_i[1] ^ video_prev_q[1];
    status_set[GEPIO_BIT_PWR] = |power_change_i;
    status_set[GEPIO_BIT_VPP12] = |(prog_volt_12v_req_i ^ vpp12_prev_q);
    status_set[GEPIO_NUM_PINS-1:0] = pin_sync.change & pin_is_input_i;
  end

  // ==========================================================
  // status: set independent of enables, write one to clear;
  // a set in the clearing cycle wins so no event is lost
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      status_q <= GEPIO_STATUS_RST;
    end else begin
      status_q <= ((status_q & ~(wr_status ? cfg_wdata_i & wmask : 16'h0000))
                | status_set) & GEPIO_EVENT_MASK;
    end
  end

  // ==========================================================
  // event output, active low, registered to stay glitch free
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      event_n_q <= 1'b1;
    end else begin
      event_n_q <= !((|(status_q & enable_q))
                     && event_pin_routed_i);
    end
  end

  assign general_event_out_n_o = event_n_q;

  // ==========================================================
  // pin outputs
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      output_q <= GEPIO_OUTPUT_RST;
    end else if (wr_output) begin
      output_q <= (output_q & ~wmask)
                | (cfg_wdata_i & wmask & GEPIO_PIN_MASK);
    end
  end

  assign multipurpose_pin_o = output_q[GEPIO_NUM_PINS-1:0];
  assign multipurpose_pin_oe_o = pin_is_output_i;

  // ==========================================================
  // read path: one cycle latency, unmapped or other function reads zero
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cfg_rdata_o <= 16'h0000;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_rd_i;
      if (!cfg_rd_i) begin
        cfg_rdata_o <= 16'h0000;
      end else if (hit(cfg_func_i, cfg_addr_i, GEPIO_OFS_STATUS)) begin
        cfg_rdata_o <= status_q;
      end else if (hit(cfg_func_i, cfg_addr_i, GEPIO_OFS_ENABLE)) begin
        cfg_rdata_o <= enable_q;
      end else if (hit(cfg_func_i, cfg_addr_i, GEPIO_OFS_INPUT)) begin
        cfg_rdata_o <= {11'h000, pin_sync.level};
      end else if (hit(cfg_func_i, cfg_addr_i, GEPIO_OFS_OUTPUT)) begin
        cfg_rdata_o <= output_q & GEPIO_PIN_MASK;
      end else begin
        cfg_rdata_o <= 16'h0000;
      end
    end
  end

  // ==========================================================
  // checks
  AST_EVENT_LEVEL: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    ((|(status_q & enable_q)) && event_pin_routed_i)
    |=> !general_event_out_n_o)
    else $error("event output not asserted for pending enabled status");

  AST_EVENT_ROUTE: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !event_pin_routed_i |=> general_event_out_n_o)
    else $error("event output asserted while not routed to a pin");

  AST_EVENT_HOLD: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
  // a clear lands one edge after its strobe, so the strobe of the
  // previous cycle may still release the output legitimately
    (!general_event_out_n_o && event_pin_routed_i && !wr_status
     && !$past(wr_status) && $stable(enable_q))
    |=> !general_event_out_n_o)
    else $error("event output released without a status clear");

  AST_ENABLE_RSVD: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (enable_q & ~GEPIO_EVENT_MASK) == 16'h0000)
    else $error("reserved enable bit became set");

  AST_OTHER_FUNC: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (cfg_wr_i && cfg_func_i != GEPIO_FUNC0) |=> $stable(enable_q)
      && $stable(output_q))
    else $error("write from another function changed a register");

  AST_VIDEO0_SET: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    $changed(video_port_on_bit_i[0]) |=> status_q[GEPIO_BIT_VID0])
    else $error("socket 0 video change did not set status");

  AST_VIDEO1_SET: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    $changed(video_port_on_bit_i[1]) |=> status_q[GEPIO_BIT_VID1])
    else $error("socket 1 video change did not set status");

  AST_POWER_SET: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (|power_change_i) |=> status_q[GEPIO_BIT_PWR])
    else $error("power change did not set status");

  AST_VPP12_SET: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    $changed(prog_volt_12v_req_i) |=> status_q[GEPIO_BIT_VPP12])
    else $error("12 V request change did not set status");

  AST_PIN_CHANGE: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (pin_sync.change[0] && pin_is_input_i[0]) |=> status_q[0])
    else $error("pin 0 change did not set status");

  AST_STATUS_CLEAR: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_status && cfg_be_i[1] && cfg_wdata_i[GEPIO_BIT_PWR]
     && !(|power_change_i)) |=> !status_q[GEPIO_BIT_PWR])
    else $error("write one did not clear power status");

  AST_INPUT_READ: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (cfg_rd_i && hit(cfg_func_i, cfg_addr_i, GEPIO_OFS_INPUT))
    |=> cfg_rvalid_o && cfg_rdata_o == {11'h000, $past(pin_sync.level)})
    else $error("input register read wrong value");

  AST_OUTPUT_ECHO: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_output && cfg_be_i[0]) |=>
      multipurpose_pin_o == $past(cfg_wdata_i[4:0]))
    else $error("written output value not driven to pins");
endmodule : gepio_top
`default_nettype wire

// *** gepio_pin_model.sv ***
`default_nettype none
// ==========================================================
// far side of the five multipurpose pins
module gepio_pin_model (
  input wire logic [4:0] drv_i,
  input wire logic [4:0] oe_i,
  input wire logic [4:0] ext_i,
  output logic [4:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven pin shows the device level, an undriven one the far side
  assign level_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule : gepio_pin_model
`default_nettype wire

// *** gepio_top_test.sv ***
`default_nettype none
module gepio_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import gepio_pkg::*;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [2:0] func = 3'h0;
  logic [7:0] addr = 8'h00;
  logic [1:0] be = 2'b11;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic rvalid;
  logic [1:0] vid = 2'b00;
  logic [1:0] pwr = 2'b00;
  logic [1:0] vpp = 2'b00;
  logic [4:0] pin_in;
  logic [4:0] pin_out;
  logic [4:0] pin_oe;
  logic [4:0] ext = 5'h00;
  logic [4:0] is_in = 5'h00;
  logic [4:0] is_out = 5'h00;
  logic routed = 1'b0;
  logic evt_n;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int bits[9] = '{GEPIO_BIT_VID0, GEPIO_BIT_VID1, GEPIO_BIT_PWR,
                  GEPIO_BIT_VPP12, 4, 3, 2, 1, 0};

  always #5 core_clk_i = ~core_clk_i;

  gepio_top i_gepio_top (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .cfg_func_i(func), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wr_i(wr),
    .cfg_wdata_i(wdata), .cfg_rd_i(rd), .cfg_rdata_o(rdata),
    .cfg_rvalid_o(rvalid), .video_port_on_bit_i(vid),
    .power_change_i(pwr), .prog_volt_12v_req_i(vpp),
    .multipurpose_pin_i(pin_in), .multipurpose_pin_o(pin_out),
    .multipurpose_pin_oe_o(pin_oe), .pin_is_input_i(is_in),
    .pin_is_output_i(is_out), .event_pin_routed_i(routed),
    .general_event_out_n_o(evt_n));

  gepio_pin_model i_gepio_pin_model (.drv_i(pin_out), .oe_i(pin_oe),
    .ext_i(ext), .level_o(pin_in));

  // ==========================================================
  // reporting
  task automatic fail(input string msg);
    n_errors++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask : fail

  task automatic stop_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail("timeout");
      stop_test();
    end
  end

  // ==========================================================
  // configuration access, strobes are one cycle long
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge core_clk_i);
    wr = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge core_clk_i);
    addr = a;
    rd = 1'b1;
    @(negedge core_clk_i);
    rd = 1'b0;
    compares++;
    if (rvalid !== 1'b1 || rdata !== exp) fail("read data");
  endtask : reg_rd

  // fire source k with enable en, then acknowledge it
  task automatic evt(input int k, input logic [15:0] en, input logic low);
    logic [15:0] m;
    m = 16'h0001 << bits[k];
    reg_wr(GEPIO_OFS_ENABLE, en);
    @(negedge core_clk_i);
    if (k == 0) vid[0] = ~vid[0];
    else if (k == 1) vid[1] = ~vid[1];
    else if (k == 2) pwr = 2'b10;
    else if (k == 3) vpp[1] = ~vpp[1];
    else ext[bits[k]] = ~ext[bits[k]];
    @(negedge core_clk_i);
    pwr = 2'b00;
    repeat (6) @(negedge core_clk_i);
    compares++;
    if (evt_n !== ~low) fail("event level");
    reg_rd(GEPIO_OFS_STATUS, m);
    reg_wr(GEPIO_OFS_STATUS, ~m);
    repeat (3) @(negedge core_clk_i);
    compares++;
    if (evt_n !== ~low) fail("event not held");
    reg_wr(GEPIO_OFS_STATUS, m);
    repeat (3) @(negedge core_clk_i);
    compares++;
    if (evt_n !== 1'b1) fail("event not released");
    reg_rd(GEPIO_OFS_STATUS, 16'h0000);
  endtask : evt

  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    reg_rd(GEPIO_OFS_ENABLE, GEPIO_ENABLE_RST);
    reg_rd(GEPIO_OFS_OUTPUT, GEPIO_OUTPUT_RST);
    reg_rd(GEPIO_OFS_STATUS, GEPIO_STATUS_RST);
    reg_wr(GEPIO_OFS_ENABLE, 16'hffff);
    reg_rd(GEPIO_OFS_ENABLE, 16'hc91f);
    reg_wr(GEPIO_OFS_ENABLE, 16'h0000);
    reg_wr(GEPIO_OFS_OUTPUT, 16'hfff5);
    reg_rd(GEPIO_OFS_OUTPUT, 16'h0015);
    be = 2'b10;
    reg_wr(GEPIO_OFS_OUTPUT, 16'h0000);
    be = 2'b11;
    func = 3'h1;
    reg_wr(GEPIO_OFS_OUTPUT, 16'h0000);
    reg_rd(GEPIO_OFS_OUTPUT, 16'h0000);
    func = 3'h0;
    reg_rd(8'hb0, 16'h0000);
    reg_rd(GEPIO_OFS_OUTPUT, 16'h0015);
    is_out = 5'h03;
    ext = 5'h0a;
    @(negedge core_clk_i);
    compares++;
    if (pin_out !== 5'h15 || pin_oe !== 5'h03) fail("pin drive");
    repeat (4) @(negedge core_clk_i);
    reg_rd(GEPIO_OFS_INPUT, 16'h0009);
    is_out = 5'h00;
    ext = 5'h00;
    repeat (4) @(negedge core_clk_i);
    is_in = 5'h1f;
    routed = 1'b1;
    repeat (6) @(negedge core_clk_i);
    reg_wr(GEPIO_OFS_STATUS, 16'hffff);
    for (int k = 0; k < 9; k++) begin
      evt(k, 16'h0001 << bits[k], 1'b1);
    end
    evt(0, 16'h7fff, 1'b0);
    routed = 1'b0;
    evt(1, 16'hffff, 1'b0);
    stop_test();
  end
endmodule : gepio_top_test
`default_nettype wire
